// >>> verilog/rdtp_pkg.sv
// constants and types for the resource data tag parser
package rdtp_pkg;
    typedef enum logic [2:0] {
        RDTP_IDLE   = 3'h0,
        RDTP_TAG    = 3'h1,
        RDTP_LEN_LO = 3'h2,
        RDTP_LEN_HI = 3'h3,
        RDTP_DATA   = 3'h4,
        RDTP_CKS    = 3'h5,
        RDTP_CHECK  = 3'h6,
        RDTP_DONE   = 3'h7
    } rdtp_state_t;

    // tag bytes and item names
    localparam logic [7:0] TAG_FIXED_IO = 8'h4b;
    localparam logic [7:0] TAG_MEM24 = 8'h81;
    localparam logic [7:0] TAG_ANSI = 8'h82;
    localparam logic [7:0] TAG_UNICODE = 8'h83;
    localparam logic [7:0] TAG_LVENDOR = 8'h84;
    localparam logic [7:0] TAG_MEM32 = 8'h85;
    localparam logic [7:0] TAG_FMEM32 = 8'h86;
    localparam logic [3:0] SNAME_VENDOR = 4'he;
    localparam logic [3:0] SNAME_END = 4'hf;
    localparam logic [6:0] LNAME_FIRST_RSVD = 7'h07;
    localparam int TAG_LARGE_BIT = 7;
    localparam logic [15:0] LEN_MEM24 = 16'h0009;
    localparam logic [15:0] LEN_MEM32 = 16'h0011;

    // information byte fields
    localparam int INFO_ROM = 6;
    localparam int INFO_SHADOW = 5;
    localparam int INFO_WHI = 4;
    localparam int INFO_WLO = 3;
    localparam int INFO_HIGH = 2;
    localparam int INFO_CACHE = 1;
    localparam int INFO_WRITE = 0;
    localparam logic [1:0] WIDTH_TOP = 2'h3;
    localparam logic [16:0] ALIGN_64K = 17'h1_0000;

    // data byte positions inside items
    localparam logic [15:0] B_FIRST = 16'h0000;
    localparam logic [15:0] B_SECOND = 16'h0001;
    localparam logic [15:0] B_THIRD = 16'h0002;
    localparam logic [15:0] B_MAX_LO = 16'h0003;
    localparam logic [15:0] B_MAX_HI = 16'h0004;
    localparam logic [15:0] B_ALN_LO = 16'h0005;
    localparam logic [15:0] B_ALN_HI = 16'h0006;
    localparam logic [15:0] B_RLEN_LO = 16'h0007;
    localparam logic [15:0] B_RLEN_HI = 16'h0008;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_IO = 12'h008;
    localparam logic [11:0] OFS_MINFO = 12'h00c;
    localparam logic [11:0] OFS_MMIN = 12'h010;
    localparam logic [11:0] OFS_MMAX = 12'h014;
    localparam logic [11:0] OFS_ALIGN = 12'h018;
    localparam logic [11:0] OFS_MLEN = 12'h01c;
    localparam logic [11:0] OFS_ITEM = 12'h020;
    localparam logic [11:0] OFS_CTRY = 12'h024;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_RESTART = 1;
endpackage

// >>> verilog/rdtp_if.sv
// decoded fields and control between parser core and registers
`timescale 1ns/1ns
`default_nettype none
interface rdtp_if;
    logic enable;
    logic restart;
    logic [31:0] status;
    logic [31:0] io;
    logic [31:0] minfo;
    logic [31:0] mmin;
    logic [31:0] mmax;
    logic [31:0] align;
    logic [31:0] mlen;
    logic [31:0] item;
    logic [31:0] ctry;
    modport core(output status, io, minfo, mmin, mmax, align, mlen, item,
        ctry, input enable, restart);
    modport regs(input status, io, minfo, mmin, mmax, align, mlen, item,
        ctry, output enable, restart);
endinterface
`default_nettype wire

// >>> verilog/rdtp_csum.sv
// modulo-256 running sum of accepted resource bytes
`timescale 1ns/1ns
`default_nettype none
module rdtp_csum (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic add,
    input wire logic [7:0] data,
    output logic [7:0] sum
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum <= 8'h00;
        end else if (clear) begin
            sum <= 8'h00;
        end else if (add) begin
            sum <= 8'(sum + data);
        end
    end
endmodule
`default_nettype wire

// >>> verilog/rdtp_apb.sv
// apb slave holding control and presenting decoded fields
`timescale 1ns/1ns
`default_nettype none
module rdtp_apb (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    rdtp_if.regs bus
);
    logic [31:0] rd_word;
    logic hit;
    logic take;

    assign take = psel && penable && pready;

    always_comb begin
        hit = 1'b1;
        rd_word = 32'h0000_0000;
        if (paddr == rdtp_pkg::OFS_CTRL) begin
            rd_word[rdtp_pkg::CTRL_ENABLE] = bus.enable;
        end else if (paddr == rdtp_pkg::OFS_STATUS) begin
            rd_word = bus.status;
        end else if (paddr == rdtp_pkg::OFS_IO) begin
            rd_word = bus.io;
        end else if (paddr == rdtp_pkg::OFS_MINFO) begin
            rd_word = bus.minfo;
        end else if (paddr == rdtp_pkg::OFS_MMIN) begin
            rd_word = bus.mmin;
        end else if (paddr == rdtp_pkg::OFS_MMAX) begin
            rd_word = bus.mmax;
        end else if (paddr == rdtp_pkg::OFS_ALIGN) begin
            rd_word = bus.align;
        end else if (paddr == rdtp_pkg::OFS_MLEN) begin
            rd_word = bus.mlen;
        end else if (paddr == rdtp_pkg::OFS_ITEM) begin
            rd_word = bus.item;
        end else if (paddr == rdtp_pkg::OFS_CTRY) begin
            rd_word = bus.ctry;
        end else begin
            hit = 1'b0;
        end
    end

    // one wait state: answer on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            // error flag stands only beside the one-cycle pready
            pslverr <= psel && penable && !pready && !hit;
            if (psel && penable && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.enable <= 1'b0;
            bus.restart <= 1'b0;
        end else begin
            bus.restart <= take && pwrite && paddr == rdtp_pkg::OFS_CTRL
                && pwdata[rdtp_pkg::CTRL_RESTART];
            if (take && pwrite && paddr == rdtp_pkg::OFS_CTRL) begin
                bus.enable <= pwdata[rdtp_pkg::CTRL_ENABLE];
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/rdtp_top.sv
// resource data tag parser: byte stream decoder with apb registers
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rdtp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic src_valid,
    input wire logic [7:0] src_data,
    output logic src_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic [7:0] out_tag
);
    rdtp_if regs_if ();

    rdtp_pkg::rdtp_state_t state;
    rdtp_pkg::rdtp_state_t next_state;
    logic accept;
    logic [7:0] tag;
    logic [7:0] len_lo;
    logic [15:0] item_len;
    logic [15:0] remaining;
    logic [15:0] idx;
    logic [9:0] io_base;
    logic [7:0] io_count;
    logic [7:0] m_info;
    logic m_is32;
    logic [31:0] m_min;
    logic [23:0] m_max;
    logic [15:0] m_align;
    logic [15:0] m_len;
    logic [15:0] country;
    logic [7:0] cks;
    logic [7:0] sum;
    logic done;
    logic csum_ok;
    logic csum_err;
    logic len_err;
    logic rsvd_name;
    logic [16:0] align_eff;
    logic width_rsvd;
    logic width32;
    logic mem_fixed;

    function automatic logic takes_byte(input rdtp_pkg::rdtp_state_t s);
        return s == rdtp_pkg::RDTP_TAG || s == rdtp_pkg::RDTP_LEN_LO
            || s == rdtp_pkg::RDTP_LEN_HI || s == rdtp_pkg::RDTP_DATA
            || s == rdtp_pkg::RDTP_CKS;
    endfunction

    function automatic logic is_large(input logic [7:0] t);
        return t[rdtp_pkg::TAG_LARGE_BIT];
    endfunction

    assign accept = src_valid && src_ready && takes_byte(state);

    rdtp_csum u_csum (
        .pclk(pclk),
        .presetn(presetn),
        .clear(regs_if.restart),
        .add(accept),
        .data(src_data),
        .sum(sum)
    );

    rdtp_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus(regs_if)
    );

    always_comb begin
        next_state = state;
        case (state)
            rdtp_pkg::RDTP_IDLE: begin
                if (regs_if.enable) begin
                    next_state = rdtp_pkg::RDTP_TAG;
                end
            end
            rdtp_pkg::RDTP_TAG: begin
                if (accept) begin
                    // large tag goes to its length bytes
                    if (is_large(src_data)) begin
                        next_state = rdtp_pkg::RDTP_LEN_LO;
                    end else if (src_data[6:3] == rdtp_pkg::SNAME_END) begin
                        next_state = rdtp_pkg::RDTP_CKS;
                    // small item length from low bits
                    end else if (src_data[2:0] != 3'h0) begin
                        next_state = rdtp_pkg::RDTP_DATA;
                    end
                end
            end
            rdtp_pkg::RDTP_LEN_LO: begin
                if (accept) begin
                    next_state = rdtp_pkg::RDTP_LEN_HI;
                end
            end
            rdtp_pkg::RDTP_LEN_HI: begin
                // zero-length large item goes straight to next tag
                if (accept) begin
                    next_state = ({src_data, len_lo} == 16'h0000)
                        ? rdtp_pkg::RDTP_TAG : rdtp_pkg::RDTP_DATA;
                end
            end
            rdtp_pkg::RDTP_DATA: begin
                // after the last data byte expect a tag
                if (accept && remaining == 16'h0001) begin
                    next_state = rdtp_pkg::RDTP_TAG;
                end
            end
            rdtp_pkg::RDTP_CKS: begin
                if (accept) begin
                    next_state = rdtp_pkg::RDTP_CHECK;
                end
            end
            rdtp_pkg::RDTP_CHECK: begin
                next_state = rdtp_pkg::RDTP_DONE;
            end
            default: begin
                next_state = rdtp_pkg::RDTP_DONE;
            end
        endcase
        if (regs_if.restart) begin
            next_state = rdtp_pkg::RDTP_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= rdtp_pkg::RDTP_IDLE;
            src_ready <= 1'b0;
        end else begin
            state <= next_state;
            src_ready <= regs_if.enable && takes_byte(next_state);
        end
    end

    // tag and length capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag <= 8'h00;
            len_lo <= 8'h00;
            item_len <= 16'h0000;
            remaining <= 16'h0000;
            idx <= 16'h0000;
            len_err <= 1'b0;
            rsvd_name <= 1'b0;
        end else if (regs_if.restart) begin
            tag <= 8'h00;
            len_lo <= 8'h00;
            item_len <= 16'h0000;
            remaining <= 16'h0000;
            idx <= 16'h0000;
            len_err <= 1'b0;
            rsvd_name <= 1'b0;
        end else if (accept) begin
            case (state)
                rdtp_pkg::RDTP_TAG: begin
                    tag <= src_data;
                    idx <= 16'h0000;
                    item_len <= 16'(src_data[2:0]);
                    remaining <= 16'(src_data[2:0]);
                    // names from 7h upward are reserved
                    if (is_large(src_data)
                        && src_data[6:0] >= rdtp_pkg::LNAME_FIRST_RSVD) begin
                        rsvd_name <= 1'b1;
                    end
                end
                rdtp_pkg::RDTP_LEN_LO: begin
                    len_lo <= src_data;
                end
                rdtp_pkg::RDTP_LEN_HI: begin
                    item_len <= {src_data, len_lo};
                    remaining <= {src_data, len_lo};
                    // memory range must carry nine bytes
                    if (tag == rdtp_pkg::TAG_MEM24
                        && {src_data, len_lo} != rdtp_pkg::LEN_MEM24) begin
                        len_err <= 1'b1;
                    end
                    // 32-bit memory range must carry seventeen
                    if (tag == rdtp_pkg::TAG_MEM32
                        && {src_data, len_lo} != rdtp_pkg::LEN_MEM32) begin
                        len_err <= 1'b1;
                    end
                end
                rdtp_pkg::RDTP_DATA: begin
                    remaining <= 16'(remaining - 16'h0001);
                    idx <= 16'(idx + 16'h0001);
                end
                default: begin
                end
            endcase
        end
    end

    // field capture from item data bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_base <= 10'h000;
            io_count <= 8'h00;
            m_info <= 8'h00;
            m_is32 <= 1'b0;
            m_min <= 32'h0000_0000;
            m_max <= 24'h00_0000;
            m_align <= 16'h0000;
            m_len <= 16'h0000;
            country <= 16'h0000;
        end else if (accept && state == rdtp_pkg::RDTP_DATA) begin
            case (tag)
                rdtp_pkg::TAG_FIXED_IO: begin
                    // base low, base bits 9:8, then count
                    if (idx == rdtp_pkg::B_FIRST) begin
                        io_base[7:0] <= src_data;
                    end else if (idx == rdtp_pkg::B_SECOND) begin
                        io_base[9:8] <= src_data[1:0];
                    end else if (idx == rdtp_pkg::B_THIRD) begin
                        io_count <= src_data;
                    end
                end
                rdtp_pkg::TAG_MEM24: begin
                    // address bytes shifted up; bits 7:0 stay zero
                    if (idx == rdtp_pkg::B_FIRST) begin
                        m_info <= src_data;
                        m_is32 <= 1'b0;
                        m_min <= 32'h0000_0000;
                        m_max <= 24'h00_0000;
                    end else if (idx == rdtp_pkg::B_SECOND) begin
                        m_min[15:8] <= src_data;
                    end else if (idx == rdtp_pkg::B_THIRD) begin
                        m_min[23:16] <= src_data;
                    end else if (idx == rdtp_pkg::B_MAX_LO) begin
                        m_max[15:8] <= src_data;
                    end else if (idx == rdtp_pkg::B_MAX_HI) begin
                        m_max[23:16] <= src_data;
                    end else if (idx == rdtp_pkg::B_ALN_LO) begin
                        m_align[7:0] <= src_data;
                    end else if (idx == rdtp_pkg::B_ALN_HI) begin
                        m_align[15:8] <= src_data;
                    end else if (idx == rdtp_pkg::B_RLEN_LO) begin
                        m_len[7:0] <= src_data;
                    end else if (idx == rdtp_pkg::B_RLEN_HI) begin
                        m_len[15:8] <= src_data;
                    end
                end
                rdtp_pkg::TAG_MEM32, rdtp_pkg::TAG_FMEM32: begin
                    // four base bytes, least significant first
                    if (idx == rdtp_pkg::B_FIRST) begin
                        m_info <= src_data;
                        m_is32 <= 1'b1;
                        m_min <= 32'h0000_0000;
                    end else if (idx <= rdtp_pkg::B_MAX_HI) begin
                        m_min[8 * (idx[2:0] - 3'h1) +: 8] <= src_data;
                    end
                end
                rdtp_pkg::TAG_UNICODE: begin
                    if (idx == rdtp_pkg::B_FIRST) begin
                        country[7:0] <= src_data;
                    end else if (idx == rdtp_pkg::B_SECOND) begin
                        country[15:8] <= src_data;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // pass-through of string and vendor bytes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_data <= 8'h00;
            out_tag <= 8'h00;
        end else begin
            out_valid <= 1'b0;
            if (accept && state == rdtp_pkg::RDTP_DATA) begin
                out_data <= src_data;
                out_tag <= tag;
                if (!is_large(tag) && tag[6:3] == rdtp_pkg::SNAME_VENDOR) begin
                    out_valid <= 1'b1;
                end
                // ANSI bytes as sized, no terminator looked for
                if (tag == rdtp_pkg::TAG_ANSI
                    || tag == rdtp_pkg::TAG_LVENDOR) begin
                    out_valid <= 1'b1;
                end
                // unicode characters after the country id
                if (tag == rdtp_pkg::TAG_UNICODE
                    && idx > rdtp_pkg::B_SECOND) begin
                    out_valid <= 1'b1;
                end
            end
        end
    end

    // checksum capture and verdict
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cks <= 8'h00;
            done <= 1'b0;
            csum_ok <= 1'b0;
            csum_err <= 1'b0;
        end else if (regs_if.restart) begin
            cks <= 8'h00;
            done <= 1'b0;
            csum_ok <= 1'b0;
            csum_err <= 1'b0;
        end else if (accept && state == rdtp_pkg::RDTP_CKS) begin
            // byte after end tag is the checksum
            cks <= src_data;
        end else if (state == rdtp_pkg::RDTP_CHECK) begin
            done <= 1'b1;
            // total including checksum must be zero, or the checksum byte itself zero
            csum_ok <= sum == 8'h00 || cks == 8'h00;
            csum_err <= !(sum == 8'h00 || cks == 8'h00);
        end
    end

    assign align_eff = (m_align == 16'h0000) ? rdtp_pkg::ALIGN_64K
        : 17'(m_align);
    // width code 11 is reserved on 24-bit items
    assign width_rsvd = !m_is32 && m_info[rdtp_pkg::INFO_WHI:rdtp_pkg::INFO_WLO]
        == rdtp_pkg::WIDTH_TOP;
    // width code 11 is 32-bit only on 32-bit items
    assign width32 = m_is32 && m_info[rdtp_pkg::INFO_WHI:rdtp_pkg::INFO_WLO]
        == rdtp_pkg::WIDTH_TOP;
    // equal bounds mark a fixed address on 24-bit items
    assign mem_fixed = !m_is32 && m_min[23:0] == m_max;

    assign regs_if.status = {8'h00, cks, tag, state, done,
        rsvd_name, len_err, csum_err, csum_ok};
    assign regs_if.io = {8'h00, io_count, 6'h00, io_base};
    assign regs_if.minfo = {21'h00_0000, mem_fixed, width32, width_rsvd,
        m_is32, m_info[rdtp_pkg::INFO_ROM], m_info[rdtp_pkg::INFO_SHADOW],
        m_info[rdtp_pkg::INFO_WHI:rdtp_pkg::INFO_WLO],
        m_info[rdtp_pkg::INFO_HIGH], m_info[rdtp_pkg::INFO_CACHE],
        m_info[rdtp_pkg::INFO_WRITE]};
    assign regs_if.mmin = m_min;
    assign regs_if.mmax = {8'h00, m_max};
    assign regs_if.align = {15'h0000, align_eff};
    // length in bytes is blocks times 256
    assign regs_if.mlen = {8'h00, m_len, 8'h00};
    assign regs_if.item = {item_len, 8'h00, tag};
    assign regs_if.ctry = {16'h0000, country};
endmodule
`default_nettype wire

// >>> bench/rdtp_src.sv
// byte source standing in for the card's resource storage
`timescale 1ns/1ns
`default_nettype none
module rdtp_src (
    input wire logic pclk,
    input wire logic src_ready,
    output logic src_valid,
    output logic [7:0] src_data
);
    logic [7:0] q[$];
    int gap = 0;
    int hold = 0;
    initial begin
        src_valid = 1'b0;
        src_data = 8'h00;
    end
    // a byte stands until taken, then the line flips
    always @(posedge pclk) begin
        if (src_valid && src_ready) begin
            src_valid <= 1'b0;
            src_data <= ~src_data;
            hold <= gap;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else if (!src_valid && q.size() > 0) begin
            src_valid <= 1'b1;
            src_data <= q.pop_front();
        end
    end
endmodule
`default_nettype wire

// >>> bench/rdtp_top_monitor.sv
// port-level checks of the resource data tag parser
`timescale 1ns/1ns
`default_nettype none
module rdtp_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic src_valid,
    input wire logic [7:0] src_data,
    input wire logic src_ready,
    input wire logic out_valid,
    input wire logic [7:0] out_tag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take; src_valid && src_ready; endsequence
    sequence s_end; src_valid && src_ready && src_data == 8'h79; endsequence
    property p_pulse; pready |=> !pready; endproperty
    property p_wait; psel && !penable ##1 psel && penable |=> pready;
    endproperty
    property p_err; pslverr |-> pready; endproperty
    property p_zero; pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    property p_stop; s_end ##[1:4] s_take |=> !src_ready; endproperty
    property p_src; out_valid |-> $past(src_valid && src_ready); endproperty
    property p_small; out_valid |-> out_tag[7] || out_tag[6:3] == 4'he;
    endproperty
    property p_large;
        out_valid && out_tag[7] |-> !(out_tag[6:0] inside {1, 5, 6});
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    a_wait: assert property (p_wait) else $error("pready late");
    a_err: assert property (p_err) else $error("pslverr alone");
    a_zero: assert property (p_zero) else $error("refused read not 0");
    a_stop: assert property (p_stop) else $error("takes past end");
    a_src: assert property (p_src) else $error("out without byte");
    a_small: assert property (p_small) else $error("small out");
    a_large: assert property (p_large) else $error("mem out");
endmodule
bind rdtp_top rdtp_top_monitor mon_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .src_valid, .src_data, .src_ready,
    .out_valid, .out_tag);
`default_nettype wire

// >>> bench/resource_data_tag_parser_tb.sv
// self-checking bench for the resource data tag parser
`timescale 1ns/1ns
`default_nettype none
module resource_data_tag_parser_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, src_valid, src_ready, out_valid;
    logic [7:0] src_data, out_data, out_tag;
    logic [7:0] sum = 8'h00;
    int num_errors = 0;
    int checks = 0;
    always #4 pclk = ~pclk;
    logic [15:0] outq[$];
    always @(posedge pclk) begin
        if (out_valid) begin
            outq.push_back({out_tag, out_data});
        end
    end
    rdtp_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .src_valid, .src_data,
        .src_ready, .out_valid, .out_data, .out_tag);
    rdtp_src src_u (.pclk, .src_ready, .src_valid, .src_data);
    task summarize();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [32:0] r);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            num_errors++;
            summarize();
        end
        @(posedge pclk);
    endtask
    task chk(input logic [11:0] a, input logic [32:0] x);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        checks++;
        if (r !== x) begin
            num_errors++;
            $display("wrong value reg %h exp %h got %h", a, x, r);
        end
    endtask
    task chk_out(input logic [15:0] x);
        logic [15:0] r;
        r = ~x;
        if (outq.size() > 0) begin
            r = outq.pop_front();
        end
        checks++;
        if (r !== x) begin
            num_errors++;
            $display("wrong value out exp %h got %h", x, r);
        end
    endtask
    task wr(input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, 12'h000, d, r);
    endtask
    task feed(input logic [7:0] b[]);
        foreach (b[i]) begin
            src_u.q.push_back(b[i]);
            sum += b[i];
        end
    endtask
    task fin(input logic [7:0] c, input logic [31:0] st);
        int n;
        feed('{8'h79, c});
        for (n = 0; n < 300 && (src_u.q.size() > 0 || src_valid); n++)
            @(posedge pclk);
        if (n == 300) begin
            num_errors++;
            summarize();
        end
        repeat (4) @(posedge pclk);
        chk(12'h004, {1'b0, st | {8'h00, c, 16'h0000}});
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(12'h000, 33'h0_0000_0000);
        chk(12'h040, 33'h1_0000_0000);
        wr(32'h0000_0001);
        // fixed i/o, small vendor data, fixed 24-bit memory range
        feed('{8'h4b, 8'h78, 8'h03, 8'h08, 8'h71, 8'haa, 8'h81, 8'h09,
            8'h00, 8'h77, 8'h34, 8'h12, 8'h34, 8'h12, 8'h00, 8'h00, 8'h02,
            8'h00});
        // zero checksum byte on a stream that does not sum to zero
        fin(8'h00, 32'h0000_79f1);
        chk(12'h008, 33'h0_0008_0378);
        chk(12'h00c, 33'h0_0000_0477);
        chk(12'h010, 33'h0_0012_3400);
        chk(12'h018, 33'h0_0001_0000);
        chk(12'h01c, 33'h0_0000_0200);
        chk(12'h020, 33'h0_0001_0079);
        chk_out(16'h71aa);
        wr(32'h0000_0003);
        sum = 8'h00;
        src_u.gap = 2;
        // card id string kept by the source, checksum chosen to sum zero
        feed('{8'h85, 8'h11, 8'h00, 8'h18, 8'h78, 8'h56, 8'h34, 8'h12,
            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00, 8'h82, 8'h03, 8'h00, 8'h41, 8'h42, 8'h43,
            8'h83, 8'h06, 8'h00, 8'hcc, 8'h01, 8'h68, 8'h69, 8'h6a, 8'h6b,
            8'h84, 8'h02, 8'h00, 8'h5a, 8'h5b, 8'h88, 8'h00,
            8'h00});
        fin(8'h87 - sum, 32'h0000_79f9);
        chk(12'h00c, 33'h0_0000_0298);
        chk(12'h010, 33'h0_1234_5678);
        chk(12'h024, 33'h0_0000_01cc);
        chk_out(16'h8241);
        chk_out(16'h8242);
        chk_out(16'h8243);
        chk_out(16'h8368);
        chk_out(16'h8369);
        chk_out(16'h836a);
        chk_out(16'h836b);
        chk_out(16'h845a);
        chk_out(16'h845b);
        wr(32'h0000_0003);
        src_u.gap = 0;
        feed('{8'h81, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00});
        fin(8'h00, 32'h0000_79f5);
        wr(32'h0000_0003);
        fin(8'h01, 32'h0000_79f2);
        summarize();
    end
endmodule
`default_nettype wire
